// ---- src/frame_delimiter_pattern_config.v ----
/*
 * Delimiter pattern registers, configuration reset field and the
 * per-rate delimiter output used by the framer and the correlator.
 * Assumes a simple synchronous register port (address, write strobe,
 * write data, read data) driven by the host interface in this clock domain.
 */
`timescale 1ns/1ps
`include "delim_cfg_map.vh"

// Functional notes
// [RULE1] 2 Mbps: octet one whole, or high
// [RULE2] Host: octet one nibbles nonzero, distinct, not A7
// [RULE3] 1 Mbps: octet two whole, or high
// [RULE4] Host: octet two nibbles nonzero, distinct, not A7
// [RULE5] 500 kbps: octet three single delimiter
// [RULE6] Host: octet three nibbles nonzero, distinct
// [RULE7] 250 kbps: octet four if proprietary, else A7
// [RULE8] Host: octet four nibbles nonzero and distinct
// [RULE9] 125 kbps: octet five is high octet
// [RULE10] Compact: octet six low at 2M, 125k
// [RULE11] Host: octet six nibbles nonzero, not A7
// [RULE12] Compact: octet seven low at 1 Mbps
// [RULE13] Field all ones resets octets; zeros releases
// [RULE14] High octet first; single octet at 500k/250k
module frame_delimiter_pattern_config (
  // Clock and reset.
  input  wire        clk,
  input  wire        sys_rst,
  // Register port.
  input  wire [6:0]  reg_addr,
  input  wire        reg_wr,
  input  wire [7:0]  reg_wdata,
  output reg  [7:0]  reg_rdata,
  // Mode inputs from the rest of the radio.
  input  wire [2:0]  air_rate,
  input  wire        compact_delimiter_mode,
  input  wire        proprietary_mac,
  // Delimiter sequencing request from the framer.
  input  wire        delim_start,
  input  wire        delim_next,
  // Delimiter outputs.
  output reg  [7:0]  delim_octet_q,
  output reg         delim_octet_valid_q,
  output reg         delim_last_q,
  output reg  [7:0]  match_high_q,
  output reg  [7:0]  match_low_q,
  output reg         match_two_octet_q,
  output reg         rate_valid_q,
  // Configuration reset state and pattern error flag.
  output wire        config_reset_active,
  output reg         pattern_error_q
);

  reg  [`CFG_RST_W-1:0] config_reset_field_q;
  reg  [7:0]            delim_pattern_2m_q;
  reg  [7:0]            delim_pattern_1m_q;
  reg  [7:0]            delim_pattern_500k_q;
  reg  [7:0]            delim_pattern_250k_q;
  reg  [7:0]            delim_high_125k_q;
  reg  [7:0]            delim_low_shared_q;
  reg  [7:0]            delim_low_1m_q;
  reg                   second_pending_q;
  wire [7:0]            sel_high;
  wire [7:0]            sel_low;
  wire                  sel_two_octet;
  wire                  sel_valid;
  wire                  cfg_hold;

  // True when either nibble equals the same-position nibble of the other octet.
  function nib_bad;
    input [7:0] a;
    input [7:0] b;
    begin
      nib_bad = (a[7:4] == b[7:4]) || (a[3:0] == b[3:0]);
    end
  endfunction

  // True when either nibble of the octet is zero.
  function zero_nib;
    input [7:0] a;
    begin
      zero_nib = (a[7:4] == 4'h0) || (a[3:0] == 4'h0);
    end
  endfunction

  // Only all ones holds the octets in reset; any other value is treated
  // as released so a half-written field cannot wedge the block.
  assign cfg_hold            = (config_reset_field_q == `CFG_RST_ALL_ONES); // [RULE13]
  assign config_reset_active = cfg_hold;

  // The reset field itself sits outside the reset it drives.
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      config_reset_field_q <= `CFG_RST_RELEASE;
    end else if (reg_wr && reg_addr == `ADDR_CFG_RESET) begin
      config_reset_field_q <= reg_wdata[`CFG_RST_W-1:0];
    end
  end

  // Pattern octets: defaults on system reset or held configuration reset.
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      delim_pattern_2m_q   <= `RST_PATTERN_2M;
      delim_pattern_1m_q   <= `RST_PATTERN_1M;
      delim_pattern_500k_q <= `RST_PATTERN_500K;
      delim_pattern_250k_q <= `RST_PATTERN_250K;
      delim_high_125k_q    <= `RST_HIGH_125K;
      delim_low_shared_q   <= `RST_LOW_SHARED;
      delim_low_1m_q       <= `RST_LOW_1M;
    end else if (cfg_hold) begin                                   // [RULE13]
      delim_pattern_2m_q   <= `RST_PATTERN_2M;
      delim_pattern_1m_q   <= `RST_PATTERN_1M;
      delim_pattern_500k_q <= `RST_PATTERN_500K;
      delim_pattern_250k_q <= `RST_PATTERN_250K;
      delim_high_125k_q    <= `RST_HIGH_125K;
      delim_low_shared_q   <= `RST_LOW_SHARED;
      delim_low_1m_q       <= `RST_LOW_1M;
    end else if (reg_wr) begin
      case (reg_addr)
        `ADDR_PATTERN_2M:   delim_pattern_2m_q   <= reg_wdata;
        `ADDR_PATTERN_1M:   delim_pattern_1m_q   <= reg_wdata;
        `ADDR_PATTERN_500K: delim_pattern_500k_q <= reg_wdata;
        `ADDR_PATTERN_250K: delim_pattern_250k_q <= reg_wdata;
        `ADDR_HIGH_125K:    delim_high_125k_q    <= reg_wdata;
        `ADDR_LOW_SHARED:   delim_low_shared_q   <= reg_wdata;
        `ADDR_LOW_1M:       delim_low_1m_q       <= reg_wdata;
        default: begin
        end
      endcase
    end
  end

  // Read mux; unmapped addresses read as zero, reserved bits too.
  always @* begin
    case (reg_addr)
      `ADDR_CFG_RESET:    reg_rdata = {2'h0, config_reset_field_q};
      `ADDR_PATTERN_2M:   reg_rdata = delim_pattern_2m_q;
      `ADDR_PATTERN_1M:   reg_rdata = delim_pattern_1m_q;
      `ADDR_PATTERN_500K: reg_rdata = delim_pattern_500k_q;
      `ADDR_PATTERN_250K: reg_rdata = delim_pattern_250k_q;
      `ADDR_HIGH_125K:    reg_rdata = delim_high_125k_q;
      `ADDR_LOW_SHARED:   reg_rdata = delim_low_shared_q;
      `ADDR_LOW_1M:       reg_rdata = delim_low_1m_q;
      default:            reg_rdata = 8'h00;
    endcase
  end

  delim_select u_select (
    .air_rate               (air_rate),
    .compact_delimiter_mode (compact_delimiter_mode),
    .proprietary_mac        (proprietary_mac),
    .delim_pattern_2m       (delim_pattern_2m_q),
    .delim_pattern_1m       (delim_pattern_1m_q),
    .delim_pattern_500k     (delim_pattern_500k_q),
    .delim_pattern_250k     (delim_pattern_250k_q),
    .delim_high_125k        (delim_high_125k_q),
    .delim_low_shared       (delim_low_shared_q),
    .delim_low_1m           (delim_low_1m_q),
    .sel_high               (sel_high),
    .sel_low                (sel_low),
    .sel_two_octet          (sel_two_octet),
    .sel_valid              (sel_valid)
  );

  // Registered correlator view of the active delimiter.
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      match_high_q      <= 8'h00;
      match_low_q       <= 8'h00;
      match_two_octet_q <= 1'b0;
      rate_valid_q      <= 1'b0;
    end else begin
      match_high_q      <= sel_high;
      match_low_q       <= sel_low;
      match_two_octet_q <= sel_two_octet;
      rate_valid_q      <= sel_valid;
    end
  end

  // Transmit sequencing: high octet on start, low octet on the next step.
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      delim_octet_q       <= 8'h00;
      delim_octet_valid_q <= 1'b0;
      delim_last_q        <= 1'b0;
      second_pending_q    <= 1'b0;
    end else if (delim_start && sel_valid) begin
      delim_octet_q       <= sel_high;                             // [RULE14]
      delim_octet_valid_q <= 1'b1;
      delim_last_q        <= ~sel_two_octet;
      second_pending_q    <= sel_two_octet;
    end else if (delim_next && second_pending_q) begin
      delim_octet_q       <= sel_low;                              // [RULE14]
      delim_octet_valid_q <= 1'b1;
      delim_last_q        <= 1'b1;
      second_pending_q    <= 1'b0;
    end else begin
      delim_octet_valid_q <= 1'b0;
    end
  end

  // Flag octets that break the host's constraints in compact-off mode, as a
  // diagnostic only: the hardware still uses whatever was written.
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pattern_error_q <= 1'b0;
    end else begin
      pattern_error_q <= !compact_delimiter_mode && (
        zero_nib(delim_pattern_2m_q) || zero_nib(delim_pattern_1m_q) ||
        zero_nib(delim_pattern_500k_q) || zero_nib(delim_pattern_250k_q) ||
        zero_nib(delim_low_shared_q) ||
        delim_pattern_2m_q == `STD_DELIM || delim_pattern_1m_q == `STD_DELIM ||
        delim_pattern_500k_q == `STD_DELIM || delim_pattern_250k_q == `STD_DELIM ||
        delim_low_shared_q == `STD_DELIM ||
        nib_bad(delim_pattern_2m_q, delim_pattern_1m_q) ||   // [RULE2] [RULE4]
        nib_bad(delim_pattern_2m_q, delim_pattern_500k_q) || // [RULE6]
        nib_bad(delim_pattern_1m_q, delim_pattern_500k_q) ||
        nib_bad(delim_pattern_250k_q, delim_low_shared_q));  // [RULE8] [RULE11]
    end
  end

endmodule // frame_delimiter_pattern_config

// ---- src/delim_cfg_map.vh ----
/*
 * Register offsets, reset values, rate codes and field constants for the
 * start-of-frame delimiter configuration block.
 * Assumes an 8-bit register port with byte addresses of 7 bits.
 */
`ifndef DELIM_CFG_MAP_VH
`define DELIM_CFG_MAP_VH

// Register byte addresses.
`define ADDR_CFG_RESET       7'h00
`define ADDR_PATTERN_2M      7'h60
`define ADDR_PATTERN_1M      7'h61
`define ADDR_PATTERN_500K    7'h62
`define ADDR_PATTERN_250K    7'h63
`define ADDR_HIGH_125K       7'h64
`define ADDR_LOW_SHARED      7'h65
`define ADDR_LOW_1M          7'h66

// Values taken after reset.
`define RST_PATTERN_2M       8'h21
`define RST_PATTERN_1M       8'hF1
`define RST_PATTERN_500K     8'h3B
`define RST_PATTERN_250K     8'hE5
`define RST_HIGH_125K        8'h4D
`define RST_LOW_SHARED       8'hA8
`define RST_LOW_1M           8'hC8

// Configuration reset field.
`define CFG_RST_W            6
`define CFG_RST_ALL_ONES     6'h3F
`define CFG_RST_RELEASE      6'h00

// Fixed delimiter of the standard MAC.
`define STD_DELIM            8'hA7

// Air rate codes.
`define RATE_2M              3'h0
`define RATE_1M              3'h1
`define RATE_500K            3'h2
`define RATE_250K            3'h3
`define RATE_125K            3'h4

`endif

// ---- src/delim_select.v ----
/*
 * Combinational selection of the active delimiter from the stored octets.
 * Assumes the octets are stable register outputs of the same clock domain.
 */
`timescale 1ns/1ps
`include "delim_cfg_map.vh"

module delim_select (
  // Mode inputs.
  input  wire [2:0]  air_rate,
  input  wire        compact_delimiter_mode,
  input  wire        proprietary_mac,
  // Stored octets.
  input  wire [7:0]  delim_pattern_2m,
  input  wire [7:0]  delim_pattern_1m,
  input  wire [7:0]  delim_pattern_500k,
  input  wire [7:0]  delim_pattern_250k,
  input  wire [7:0]  delim_high_125k,
  input  wire [7:0]  delim_low_shared,
  input  wire [7:0]  delim_low_1m,
  // Selected delimiter.
  output reg  [7:0]  sel_high,
  output reg  [7:0]  sel_low,
  output reg         sel_two_octet,
  output reg         sel_valid
);

  // Pick high and low octets by rate; low is only meaningful for two octets.
  always @* begin
    sel_high      = 8'h00;
    sel_low       = 8'h00;
    sel_two_octet = 1'b0;
    sel_valid     = 1'b1;
    case (air_rate)
      `RATE_2M: begin
        sel_high      = delim_pattern_2m;                              // [RULE1]
        sel_two_octet = compact_delimiter_mode;                        // [RULE1]
        sel_low       = compact_delimiter_mode ? delim_low_shared : 8'h00; // [RULE10]
      end
      `RATE_1M: begin
        sel_high      = delim_pattern_1m;                              // [RULE3]
        sel_two_octet = compact_delimiter_mode;                        // [RULE3]
        sel_low       = compact_delimiter_mode ? delim_low_1m : 8'h00; // [RULE12]
      end
      `RATE_500K: begin
        sel_high = delim_pattern_500k;                                 // [RULE5] [RULE14]
      end
      `RATE_250K: begin
        sel_high = proprietary_mac ? delim_pattern_250k : `STD_DELIM;  // [RULE7] [RULE14]
      end
      `RATE_125K: begin
        sel_high      = delim_high_125k;                               // [RULE9]
        sel_low       = delim_low_shared;                              // [RULE10]
        sel_two_octet = 1'b1;                                          // [RULE9]
      end
      default: begin
        sel_valid = 1'b0;
      end
    endcase
  end

endmodule // delim_select

// ---- testbench/delim_cfg_chk_sva.sv ----
/* Port checker for the delimiter configuration block.
   Assumes one clock domain and an asynchronous active-high reset. */
`timescale 1ns/1ps
module delim_cfg_chk (
  // Clock, reset and inputs.
  input wire       clk, sys_rst, reg_wr, compact_delimiter_mode, proprietary_mac,
  input wire       delim_start, delim_next,
  input wire [6:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire [2:0] air_rate,
  // Outputs.
  input wire       delim_octet_valid_q, delim_last_q, match_two_octet_q, rate_valid_q,
  input wire       config_reset_active,
  input wire [7:0] match_high_q, match_low_q
);
  // Outputs are registered, so each check looks one edge after its cause.
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_std_fixed: assert property (
    air_rate == 3'h3 && !proprietary_mac |=> match_high_q == 8'hA7 && !match_two_octet_q)
    else $error("Standard 250k delimiter is not the fixed pattern.");
  a_single_500k: assert property (
    air_rate == 3'h2 |=> !match_two_octet_q && match_low_q == 8'h00)
    else $error("500k delimiter is not single octet.");
  a_two_125k: assert property (
    air_rate == 3'h4 |=> match_two_octet_q)
    else $error("125k delimiter is not two octets.");
  a_compact_pair: assert property (
    air_rate <= 3'h1 && compact_delimiter_mode |=> match_two_octet_q)
    else $error("Compact mode did not select two octets.");
  a_plain_single: assert property (
    air_rate <= 3'h1 && !compact_delimiter_mode |=> !match_two_octet_q && match_low_q == 8'h00)
    else $error("Non-compact delimiter is not single octet.");
  a_rate_known: assert property (
    air_rate > 3'h4 |=> !rate_valid_q)
    else $error("Unknown rate flagged valid.");
  a_start_single: assert property (
    delim_start && air_rate == 3'h2 |=> delim_octet_valid_q && delim_last_q)
    else $error("Single octet start not answered.");
  a_start_high: assert property (
    delim_start && air_rate == 3'h4 |=>
      delim_octet_valid_q && !delim_last_q ##1 (!delim_last_q || delim_octet_valid_q))
    else $error("Two octet start did not give the high octet first.");
  a_low_follows: assert property (
    delim_octet_valid_q && !delim_last_q && delim_next && !delim_start |=>
      delim_octet_valid_q && delim_last_q)
    else $error("Low octet did not follow the high octet.");
  a_after_last: assert property (
    delim_octet_valid_q && delim_last_q && !delim_start |=> !delim_octet_valid_q)
    else $error("Octet pulse after the last octet.");
  a_cfg_hold: assert property (
    reg_wr && reg_addr == 7'h00 && reg_wdata == 8'h3F |=> config_reset_active [*2] or ##1 reg_wr)
    else $error("Configuration reset did not take hold.");
  a_cfg_free: assert property (
    reg_wr && reg_addr == 7'h00 && reg_wdata == 8'h00 |=> !config_reset_active)
    else $error("Configuration reset not released.");
  c_two: cover property (delim_octet_valid_q && !delim_last_q ##1 delim_octet_valid_q);
  c_std: cover property (air_rate == 3'h3 && !proprietary_mac);
  c_cfg: cover property (config_reset_active);
endmodule // delim_cfg_chk

bind frame_delimiter_pattern_config delim_cfg_chk delim_cfg_chk_i (.clk(clk), .sys_rst(sys_rst),
  .reg_wr(reg_wr), .compact_delimiter_mode(compact_delimiter_mode),
  .proprietary_mac(proprietary_mac), .delim_start(delim_start), .delim_next(delim_next),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .air_rate(air_rate),
  .delim_octet_valid_q(delim_octet_valid_q), .delim_last_q(delim_last_q),
  .match_two_octet_q(match_two_octet_q), .rate_valid_q(rate_valid_q),
  .config_reset_active(config_reset_active), .match_high_q(match_high_q),
  .match_low_q(match_low_q));

// ---- testbench/delim_rx_model.sv ----
/* Far-end receiver that assembles the delimiter octets it is sent.
   Assumes octets come with a one-cycle valid pulse in the same clock. */
`timescale 1ns/1ps
module delim_rx_model (
  // Clock, reset and octet stream.
  input wire       clk, sys_rst, octet_valid, octet_last,
  input wire [7:0] octet,
  // Assembled delimiter.
  output reg [7:0] rx_high, rx_low,
  output reg       rx_two, rx_done
);
  reg got_first;
  // The first octet is the high one; a second octet is the low one.
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      {rx_high, rx_low, rx_two, rx_done, got_first} <= 19'h0;
    end else begin
      rx_done <= octet_valid && octet_last;
      if (octet_valid && !got_first) begin
        rx_high <= octet;
        rx_low  <= 8'h00;
        rx_two  <= 1'h0;
      end
      if (octet_valid && got_first) begin
        rx_low <= octet;
        rx_two <= 1'h1;
      end
      if (octet_valid) got_first <= !octet_last;
    end
  end
endmodule // delim_rx_model

// ---- testbench/tb_frame_delimiter_pattern_config.sv ----
/* Self-checking bench for the delimiter configuration block.
   Assumes the register map header and the receiver model beside it. */
`timescale 1ns/1ps
module tb_frame_delimiter_pattern_config;
  reg        clk = 1'h0, sys_rst = 1'h1, reg_wr = 1'h0, compact_delimiter_mode = 1'h0;
  reg        proprietary_mac = 1'h0, delim_start = 1'h0, delim_next = 1'h0;
  reg  [6:0] reg_addr = 7'h00;
  reg  [7:0] reg_wdata = 8'h00;
  reg  [2:0] air_rate = 3'h0;
  wire [7:0] reg_rdata, delim_octet_q, match_high_q, match_low_q, rx_high, rx_low;
  wire       delim_octet_valid_q, delim_last_q, match_two_octet_q, rate_valid_q;
  wire       config_reset_active, rx_two, rx_done, pattern_error_q;
  int        err_total = 0, cmp_count = 0, i;
  reg [21:0] rows [0:7]; // Rate, compact, proprietary, high, low, two octets.
  reg [7:0]  dflt [0:6];
  reg [7:0]  np [0:6];

  frame_delimiter_pattern_config frame_delimiter_pattern_config_i (.clk(clk),
    .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .air_rate(air_rate), .compact_delimiter_mode(compact_delimiter_mode),
    .proprietary_mac(proprietary_mac), .delim_start(delim_start), .delim_next(delim_next),
    .delim_octet_q(delim_octet_q), .delim_octet_valid_q(delim_octet_valid_q),
    .delim_last_q(delim_last_q), .match_high_q(match_high_q), .match_low_q(match_low_q),
    .match_two_octet_q(match_two_octet_q), .rate_valid_q(rate_valid_q),
    .config_reset_active(config_reset_active), .pattern_error_q(pattern_error_q));
  delim_rx_model delim_rx_model_i (.clk(clk), .sys_rst(sys_rst),
    .octet_valid(delim_octet_valid_q), .octet_last(delim_last_q), .octet(delim_octet_q),
    .rx_high(rx_high), .rx_low(rx_low), .rx_two(rx_two), .rx_done(rx_done));

  always #5 clk = ~clk;

  task automatic close_out;
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string name, input [7:0] exp, input [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask
  // Writes hold the strobe across calls, so a run of them is back to back.
  task automatic wr(input [6:0] a, input [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'h1;
  endtask
  task automatic wend;
    @(negedge clk);
    reg_wr = 1'h0;
  endtask
  task automatic rdchk(input [6:0] a, input [7:0] exp, input string name);
    @(negedge clk);
    reg_addr = a;
    #1 chk(name, exp, reg_rdata);
  endtask
  // One delimiter request; the low octet is asked for only when two are due.
  task automatic frame(input two);
    int n;
    @(negedge clk);
    delim_start = 1'h1;
    @(negedge clk);
    delim_start = 1'h0;
    delim_next = two;
    @(negedge clk);
    delim_next = 1'h0;
    for (n = 0; n < 8 && rx_done !== 1'h1; n++) @(negedge clk);
    if (n == 8) begin
      err_total++;
      close_out();
    end
  endtask

  initial begin
    rows[0] = {3'h0, 2'h0, 8'h21, 8'h00, 1'h0};
    rows[1] = {3'h0, 2'h2, 8'h21, 8'hA8, 1'h1};
    rows[2] = {3'h1, 2'h0, 8'hF1, 8'h00, 1'h0};
    rows[3] = {3'h1, 2'h2, 8'hF1, 8'hC8, 1'h1};
    rows[4] = {3'h2, 2'h2, 8'h3B, 8'h00, 1'h0};
    rows[5] = {3'h3, 2'h1, 8'hE5, 8'h00, 1'h0};
    rows[6] = {3'h3, 2'h0, 8'hA7, 8'h00, 1'h0};
    rows[7] = {3'h4, 2'h0, 8'h4D, 8'hA8, 1'h1};
    {dflt[0], dflt[1], dflt[2], dflt[3], dflt[4], dflt[5], dflt[6]} = 56'h21F13BE54DA8C8;
    {np[0], np[1], np[2], np[3], np[4], np[5], np[6]} = 56'h516273844C953D;
    repeat (8) @(posedge clk);
    @(negedge clk);
    sys_rst = 1'h0;
    for (i = 0; i < 7; i++) rdchk(7'h60 + i[6:0], dflt[i], "reset value");
    rdchk(7'h70, 8'h00, "unmapped read");
    // Default octets one and two share a low nibble, which compact-off forbids.
    chk("pattern error", 8'h01, {7'h00, pattern_error_q});
    $display("Test reset values done");
    for (i = 0; i < 8; i++) begin
      @(negedge clk);
      {air_rate, compact_delimiter_mode, proprietary_mac} = rows[i][21:17];
      @(negedge clk);
      chk("match high", rows[i][16:9], match_high_q);
      chk("match low", rows[i][8:1], match_low_q);
      chk("two octets", {7'h00, rows[i][0]}, {7'h00, match_two_octet_q});
      frame(rows[i][0]);
      chk("rx high", rows[i][16:9], rx_high);
      chk("rx low", rows[i][8:1], rx_low);
      chk("rx two", {7'h00, rows[i][0]}, {7'h00, rx_two});
    end
    $display("Test rate table done");
    // Host writes a legal set, back to back, then compact 1 Mbps uses it.
    for (i = 0; i < 7; i++) wr(7'h60 + i[6:0], np[i]);
    wend();
    for (i = 0; i < 7; i++) rdchk(7'h60 + i[6:0], np[i], "written value");
    chk("pattern clean", 8'h00, {7'h00, pattern_error_q});
    {air_rate, compact_delimiter_mode} = 4'h3;
    repeat (2) @(negedge clk);
    chk("match high 1m", 8'h62, match_high_q);
    chk("match low 1m", 8'h3D, match_low_q);
    $display("Test written patterns done");
    // Configuration reset restores defaults and refuses writes while held.
    wr(7'h00, 8'h3F);
    wr(7'h61, 8'h11);
    wend();
    chk("reset held", 8'h01, {7'h00, config_reset_active});
    rdchk(7'h61, 8'hF1, "default in reset");
    wr(7'h00, 8'h00);
    wend();
    chk("reset freed", 8'h00, {7'h00, config_reset_active});
    rdchk(7'h66, 8'hC8, "default after reset");
    $display("Test configuration reset done");
    // An unknown rate code gives no octet.
    @(negedge clk);
    air_rate = 3'h5;
    delim_start = 1'h1;
    @(negedge clk);
    delim_start = 1'h0;
    chk("octet on bad rate", 8'h00, {7'h00, delim_octet_valid_q});
    chk("rate valid", 8'h00, {7'h00, rate_valid_q});
    // A step request with no low octet pending must give nothing.
    delim_next = 1'h1;
    @(negedge clk);
    delim_next = 1'h0;
    chk("octet on stray next", 8'h00, {7'h00, delim_octet_valid_q});
    $display("Test invalid rate done");
    close_out();
  end
endmodule // tb_frame_delimiter_pattern_config
